// file: verilog/sse_stack_regs.svh
// offsets, field positions, reset values of the sequence stack entries
`ifndef SSE_STACK_REGS_SVH
`define SSE_STACK_REGS_SVH
`define SSE_OFS_SLOT6 6'h26
`define SSE_OFS_SLOT7 6'h27
`define SSE_OFS_SLOT8 6'h28
`define SSE_OFS_SLOT9 6'h29
`define SSE_OFS_SLOT10 6'h2A
`define SSE_OFS_SLOT11 6'h2B
`define SSE_OFS_SLOT12 6'h2C
`define SSE_DIR_BIT 15
`define SSE_ADDR_HI 14
`define SSE_ADDR_LO 9
`define SSE_RET_BIT 8
`define SSE_CHB_HI 7
`define SSE_CHB_LO 4
`define SSE_CHA_HI 3
`define SSE_CHA_LO 0
`define SSE_RST_SLOT6 16'h4C66
`define SSE_RST_SLOT7 16'h4F77
`define SSE_RST_SLOT8 16'h5000
`define SSE_RST_SLOT9 16'h5200
`define SSE_RST_SLOT10 16'h5400
`define SSE_RST_SLOT11 16'h5600
`define SSE_RST_SLOT12 16'h5800
`endif

// file: verilog/sse_pkg.sv
// types shared by the sequence stack bank
package sse_pkg;
    typedef enum logic [1:0] {
        SSE_IDLE = 2'b01,
        SSE_RUN = 2'b10
    } sse_state_type;
    typedef logic [15:0] sse_word_type;
    typedef logic [2:0] sse_index_type;
endpackage

// file: verilog/sse_entry.sv
// one stack entry: direction bit, fixed address field, return flag, channel picks
`include "sse_stack_regs.svh"
module sse_entry
    import sse_pkg::*;
#(
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic wrEn,
    input wire logic [15:0] wrData,
    output sse_word_type entryWord
);
    logic dirQ;
    logic retQ;
    logic [3:0] pickBQ;
    logic [3:0] pickAQ;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dirQ <= RESET_VAL[`SSE_DIR_BIT];
            retQ <= RESET_VAL[`SSE_RET_BIT];
            pickBQ <= RESET_VAL[`SSE_CHB_HI:`SSE_CHB_LO];
            pickAQ <= RESET_VAL[`SSE_CHA_HI:`SSE_CHA_LO];
        end else if (wrEn) begin
            dirQ <= wrData[`SSE_DIR_BIT];
            retQ <= wrData[`SSE_RET_BIT];
            pickBQ <= wrData[`SSE_CHB_HI:`SSE_CHB_LO];
            pickAQ <= wrData[`SSE_CHA_HI:`SSE_CHA_LO];
        end
    end

    // address field is the entry's own address, never stored
    assign entryWord = {dirQ, RESET_VAL[`SSE_ADDR_HI:`SSE_ADDR_LO], retQ, pickBQ, pickAQ};
endmodule

// file: verilog/sse_stepper.sv
// step pointer over the stack entries of this bank
module sse_stepper
    import sse_pkg::*;
#(
    parameter int DEPTH = 7
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic enterBank,
    input wire logic convDone,
    input wire logic curReturn,
    output sse_index_type stepIndex,
    output logic bankActive,
    output logic wrapToFirst,
    output logic passOnward
);
    sse_state_type state_q;
    sse_index_type idx_q;
    logic wrap_q;
    logic pass_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SSE_IDLE;
            idx_q <= 3'h0;
            wrap_q <= 1'b0;
            pass_q <= 1'b0;
        end else begin
            wrap_q <= 1'b0;
            pass_q <= 1'b0;
            case (state_q)
                SSE_IDLE: begin
                    if (enterBank) begin
                        state_q <= SSE_RUN;
                        idx_q <= 3'h0;
                    end
                end
                SSE_RUN: begin
                    if (convDone && curReturn) begin
                        state_q <= SSE_IDLE;
                        idx_q <= 3'h0;
                        wrap_q <= 1'b1;
                    end else if (convDone && idx_q == 3'(DEPTH - 1)) begin
                        state_q <= SSE_IDLE;
                        idx_q <= 3'h0;
                        pass_q <= 1'b1;
                    end else if (convDone) begin
                        idx_q <= 3'(idx_q + 3'h1);
                    end
                end
                default: begin
                    state_q <= SSE_IDLE;
                end
            endcase
        end
    end

    assign stepIndex = idx_q;
    assign bankActive = (state_q == SSE_RUN);
    assign wrapToFirst = wrap_q;
    assign passOnward = pass_q;
endmodule

// file: verilog/sse_stack_bank.sv
// sequence stack entries 0x26..0x2C with register port and step logic
`include "sse_stack_regs.svh"
module sse_stack_bank
    import sse_pkg::*;
#(
    parameter int DEPTH = 7
) (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [5:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic enterBank,
    input wire logic convDone,
    output logic [3:0] chanPickA,
    output logic [3:0] chanPickB,
    output logic [2:0] stepIndex,
    output logic bankActive,
    output logic wrapToFirst,
    output logic passOnward
);
    localparam logic [15:0] RESET_TAB [0:6] = '{
        `SSE_RST_SLOT6, `SSE_RST_SLOT7, `SSE_RST_SLOT8, `SSE_RST_SLOT9,
        `SSE_RST_SLOT10, `SSE_RST_SLOT11, `SSE_RST_SLOT12
    };

    sse_word_type entryQ [0:DEPTH-1];
    logic [DEPTH-1:0] wrHit;
    logic [15:0] rdata_q;
    logic [3:0] pickA_q;
    logic [3:0] pickB_q;
    sse_word_type curWord;
    sse_index_type idx;

    // entry slot for an address, or DEPTH when unmapped
    function automatic int slotOf(input logic [5:0] a);
        int s;
        s = DEPTH;
        if (a >= `SSE_OFS_SLOT6 && a <= `SSE_OFS_SLOT12) begin
            s = int'(a - `SSE_OFS_SLOT6);
        end
        return s;
    endfunction

    genvar g;
    generate
        for (g = 0; g < DEPTH; g++) begin : gen_entry
            // write taken only when the address field names this entry
            assign wrHit[g] = regWr && slotOf(regAddr) == g
                && regWdata[`SSE_ADDR_HI:`SSE_ADDR_LO] == regAddr;
            sse_entry #(
                .RESET_VAL(RESET_TAB[g])
            ) u_entry (
                .core_clk(core_clk),
                .arst_n(arst_n),
                .wrEn(wrHit[g]),
                .wrData(regWdata),
                .entryWord(entryQ[g])
            );
        end
    endgenerate

    // read data one cycle after the strobe, zero for unmapped
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= 16'h0000;
        end else if (regRd) begin
            if (slotOf(regAddr) < DEPTH) begin
                rdata_q <= entryQ[slotOf(regAddr)];
            end else begin
                rdata_q <= 16'h0000;
            end
        end
    end
    assign regRdata = rdata_q;

    sse_stepper #(
        .DEPTH(DEPTH)
    ) u_stepper (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .enterBank(enterBank),
        .convDone(convDone),
        .curReturn(curWord[`SSE_RET_BIT]),
        .stepIndex(idx),
        .bankActive(bankActive),
        .wrapToFirst(wrapToFirst),
        .passOnward(passOnward)
    );
    assign stepIndex = idx;

    always_comb begin
        curWord = 16'h0000;
        if (int'(idx) < DEPTH) begin
            curWord = entryQ[idx];
        end
    end

    // channel picks follow the current entry while bankActive, and hold their value while idle
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pickA_q <= 4'h0;
            pickB_q <= 4'h0;
        end else if (bankActive) begin
            pickA_q <= curWord[`SSE_CHA_HI:`SSE_CHA_LO];
            pickB_q <= curWord[`SSE_CHB_HI:`SSE_CHB_LO];
        end
    end
    assign chanPickA = pickA_q;
    assign chanPickB = pickB_q;

    // helper: high only in the first cycle after reset release
    logic firstQ;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            firstQ <= 1'b1;
        end else begin
            firstQ <= 1'b0;
        end
    end

    // helper: slot addressed by the bus, as int
    int busSlot;
    assign busSlot = slotOf(regAddr);

    a_dir_stored: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot < DEPTH && regWdata[14:9] == regAddr
        |=> entryQ[$past(busSlot)][15] == $past(regWdata[15])
    ) else $error("direction bit not stored");

    a_addr_fixed: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regRd && busSlot < DEPTH
        |=> regRdata[14:9] == $past(regAddr)
    ) else $error("address field does not match entry");

    a_step_next: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive && convDone && !curWord[8] && idx < 3'(DEPTH - 1)
        |=> bankActive && stepIndex == $past(stepIndex) + 3'h1
    ) else $error("no advance to next entry");

    a_step_wrap: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive && convDone && curWord[8]
        |=> wrapToFirst && stepIndex == 3'h0 ##1 !wrapToFirst
    ) else $error("no return to first entry");

    a_pick_b: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive |=> chanPickB == $past(curWord[7:4])
    ) else $error("converter B pick wrong");

    a_pick_a: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive |=> chanPickA == $past(curWord[3:0])
    ) else $error("converter A pick wrong");

    a_reset_slot6: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        firstQ |-> entryQ[0] == 16'h4C66
    ) else $error("entry 0x26 reset value wrong");

    a_reset_slot7: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        firstQ |-> entryQ[1] == 16'h4F77 && entryQ[1][8]
    ) else $error("entry 0x27 reset value wrong");

    a_reset_upper: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        firstQ |-> entryQ[2][8:0] == 9'h000 && entryQ[6] == 16'h5800
            && entryQ[4][15:9] == 7'h2A
    ) else $error("upper entry reset value wrong");

    a_pass_last: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive && convDone && !curWord[8] && idx == 3'(DEPTH - 1)
        |=> passOnward && !bankActive
    ) else $error("last entry does not pass onward");

    a_rd_data: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regRd && busSlot >= DEPTH |=> regRdata == 16'h0000
    ) else $error("unmapped read not zero");

    a_wr_refused: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot < DEPTH && regWdata[14:9] != regAddr
        |=> entryQ[$past(busSlot)] == $past(entryQ[busSlot])
    ) else $error("mismatched address field was stored");

    a_unmapped_wr: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot >= DEPTH && !$isunknown(regAddr)
        |=> $stable(entryQ[0]) && $stable(entryQ[6])
    ) else $error("unmapped write changed an entry");

    a_ret_stored: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot < DEPTH && regWdata[14:9] == regAddr
        |=> entryQ[$past(busSlot)][8] == $past(regWdata[8])
    ) else $error("return flag not stored");

    a_chb_stored: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot < DEPTH && regWdata[14:9] == regAddr
        |=> entryQ[$past(busSlot)][7:4] == $past(regWdata[7:4])
    ) else $error("converter B pick not stored");

    a_cha_stored: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regWr && busSlot < DEPTH && regWdata[14:9] == regAddr
        |=> entryQ[$past(busSlot)][3:0] == $past(regWdata[3:0])
    ) else $error("converter A pick not stored");

    a_rd_mapped: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        regRd && busSlot < DEPTH
        |=> regRdata == $past(entryQ[busSlot])
    ) else $error("read data does not match entry");

    a_rd_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !regRd |=> $stable(regRdata)
    ) else $error("read data moved without a read");

    a_rd_reset: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        firstQ |-> regRdata == 16'h0000
    ) else $error("read data not zero after reset");

    a_idle_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !bankActive && !enterBank |=> !bankActive
    ) else $error("bank left idle without entry");

    a_idle_done: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !bankActive && convDone && !enterBank
        |=> !bankActive && !wrapToFirst && !passOnward
    ) else $error("conversion end acted on while idle");

    a_enter_first: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !bankActive && enterBank |=> bankActive && stepIndex == 3'h0
    ) else $error("entry does not start at first slot");

    a_enter_busy: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive && enterBank && !convDone
        |=> bankActive && $stable(stepIndex)
    ) else $error("entry pulse disturbed a running bank");

    a_step_hold: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        bankActive && !convDone |=> bankActive && $stable(stepIndex)
    ) else $error("step moved without conversion end");

    a_idx_range: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        stepIndex <= 3'(DEPTH - 1)
    ) else $error("step index beyond last entry");

    a_wrap_once: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        wrapToFirst |=> !wrapToFirst
    ) else $error("wrap pulse longer than one cycle");

    a_pass_once: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        passOnward |=> !passOnward
    ) else $error("pass pulse longer than one cycle");

    a_wrap_pass_excl: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !(wrapToFirst && passOnward)
    ) else $error("wrap and pass at once");

    a_wrap_state: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        wrapToFirst |-> !bankActive && stepIndex == 3'h0
    ) else $error("wrap pulse without return to first slot");

    a_picks_idle: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        !bankActive |=> $stable(chanPickA) && $stable(chanPickB)
    ) else $error("channel picks moved while idle");

    a_slot6_addr: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        entryQ[0][14:9] == 6'h26
    ) else $error("entry 0x26 address field wrong");

    a_slot7_addr: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        entryQ[1][14:9] == 6'h27
    ) else $error("entry 0x27 address field wrong");

    a_reset_mid: assert property (
        @(posedge core_clk) disable iff (!arst_n)
        firstQ |-> entryQ[3] == 16'h5200 && entryQ[5] == 16'h5600
    ) else $error("middle entry reset value wrong");

    // every slot keeps its own address field
    generate
        for (g = 0; g < DEPTH; g++) begin : gen_addr_chk
            a_addr_const: assert property (
                @(posedge core_clk) disable iff (!arst_n)
                entryQ[g][14:9] == RESET_TAB[g][14:9]
            ) else $error("address field drifted");
        end
    endgenerate
endmodule

// file: tb/sse_stack_bank_bench.sv
// self-checking bench for the sequence stack bank
module sse_stack_bank_bench;
    import sse_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [5:0] regAddr = 6'h00;
    logic [15:0] regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    logic enterBank = 1'b0;
    logic convDone = 1'b0;
    logic [15:0] regRdata;
    logic [3:0] chanPickA;
    logic [3:0] chanPickB;
    logic [2:0] stepIndex;
    logic bankActive;
    logic wrapToFirst;
    logic passOnward;
    int num_errors = 0;
    int samples_checked = 0;
    int wrapCnt = 0;
    int passCnt = 0;
    int expWrap = 0;
    int expPass = 0;
    logic [15:0] expWord [7];

    sse_stack_bank #(.DEPTH(7)) sse_stack_bank_i (
        .core_clk(core_clk), .arst_n(arst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .enterBank(enterBank),
        .convDone(convDone), .chanPickA(chanPickA), .chanPickB(chanPickB),
        .stepIndex(stepIndex), .bankActive(bankActive), .wrapToFirst(wrapToFirst),
        .passOnward(passOnward)
    );

    always #5 core_clk = ~core_clk;

    // one-cycle pulses are tallied here
    always @(posedge core_clk) begin
        if (wrapToFirst === 1'b1) wrapCnt++;
        if (passOnward === 1'b1) passCnt++;
    end

    function automatic logic [15:0] resetWord(int i);
        logic [5:0] a;
        a = 6'h26 + 6'(i);
        return {1'b0, a, 1'(i == 1), (i == 0) ? 8'h66 : (i == 1) ? 8'h77 : 8'h00};
    endfunction

    task automatic chk(logic [15:0] seen, logic [15:0] exp, string msg);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic regWrite(logic [5:0] a, logic [15:0] d);
        @(posedge core_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic regRead(logic [5:0] a, output logic [15:0] d);
        @(posedge core_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic checkAll();
        logic [15:0] v;
        for (int i = 0; i < 7; i++) begin
            regRead(6'h26 + 6'(i), v);
            chk(v, expWord[i], "entry readback");
        end
        regRead(6'h2D, v);
        chk(v, 16'h0000, "unmapped read");
    endtask

    task automatic walk();
        logic r;
        @(posedge core_clk);
        enterBank <= 1'b1;
        @(posedge core_clk);
        enterBank <= 1'b0;
        for (int i = 0; i < 7; i++) begin
            repeat (2) @(posedge core_clk);
            #1;
            chk(16'(bankActive), 16'h0001, "active while stepping");
            chk(16'(stepIndex), 16'(i), "step index");
            chk(16'(chanPickA), 16'(expWord[i][3:0]), "pick A");
            chk(16'(chanPickB), 16'(expWord[i][7:4]), "pick B");
            r = expWord[i][8];
            @(posedge core_clk);
            convDone <= 1'b1;
            @(posedge core_clk);
            convDone <= 1'b0;
            if (r) expWrap++;
            else if (i == 6) expPass++;
            if (r || i == 6) break;
        end
        repeat (2) @(posedge core_clk);
        #1;
        chk(16'(wrapCnt), 16'(expWrap), "wrap pulses");
        chk(16'(passCnt), 16'(expPass), "pass pulses");
        chk(16'(bankActive), 16'h0000, "idle after leaving");
        if (r) chk(16'(stepIndex), 16'h0000, "back to first");
    endtask

    initial begin
        logic [15:0] d;
        int k;
        void'($urandom(47622));
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) expWord[i] = resetWord(i);
        checkAll();
        // convDone while idle must not move anything
        @(posedge core_clk);
        convDone <= 1'b1;
        @(posedge core_clk);
        convDone <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(16'(bankActive), 16'h0000, "idle convDone");
        walk();
        for (int round = 0; round < 6; round++) begin
            for (int i = 0; i < 7; i++) begin
                d = 16'($urandom);
                d[14:9] = 6'h26 + 6'(i);
                d[8] = (round > 0) && ($urandom % 4 == 0);
                regWrite(d[14:9], d);
                expWord[i] = d;
            end
            // address field not matching the target is refused
            k = $urandom % 7;
            d = 16'($urandom);
            d[14:9] = (6'h26 + 6'(k)) ^ 6'h01;
            regWrite(6'h26 + 6'(k), d);
            d[14:9] = 6'h2D;
            regWrite(6'h2D, d);
            checkAll();
            walk();
        end
        // reset in mid-walk returns everything to defaults
        @(posedge core_clk);
        enterBank <= 1'b1;
        @(posedge core_clk);
        enterBank <= 1'b0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1;
        chk(16'(bankActive), 16'h0000, "idle in reset");
        chk(16'(chanPickA), 16'h0000, "pick A in reset");
        chk(16'(chanPickB), 16'h0000, "pick B in reset");
        chk(16'(stepIndex), 16'h0000, "index in reset");
        @(posedge core_clk);
        arst_n <= 1'b1;
        for (int i = 0; i < 7; i++) expWord[i] = resetWord(i);
        checkAll();
        walk();
        summarize();
    end

    // watchdog against a hung run
    initial begin
        #200000;
        num_errors++;
        summarize();
    end
endmodule
